// File: core/mbm_server.sv
`timescale 1ns/100ps
module mbm_server #(
  parameter int TICK_CYCLES = mbm_pkg::TICK_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  req_unit,
  input  wire logic [7:0]  req_func,
  input  wire logic [15:0] req_raddr,
  input  wire logic [7:0]  req_rcount,
  input  wire logic [15:0] req_waddr,
  input  wire logic [7:0]  req_wcount,
  input  wire logic        req_wvalid,
  input  wire logic [15:0] req_wdata,
  output logic             req_wready,
  output logic             rsp_rvalid,
  output logic      [15:0] rsp_rdata,
  output logic             rsp_done,
  output logic      [7:0]  rsp_exc,
  output logic             gm_valid,
  output logic             gm_we,
  output logic      [15:0] gm_addr,
  output logic      [15:0] gm_wdata,
  input  wire logic        gm_ready,
  input  wire logic [15:0] gm_rdata,
  input  wire logic        app_valid,
  input  wire logic        app_we,
  input  wire logic        app_bank,
  input  wire logic [4:0]  app_addr,
  input  wire logic [15:0] app_wdata,
  output logic             app_ready,
  output logic             app_rvalid,
  output logic      [15:0] app_rdata,
  input  wire logic        xchg_req,
  input  wire logic [3:0]  xchg_idx,
  input  wire logic        conn_up,
  output logic             conn_try,
  output logic      [31:0] conn_ip,
  output logic      [7:0]  conn_unit,
  output logic             conn_fail
);
  import mbm_pkg::*;

  function automatic logic fits(input logic [15:0] addr, input logic [7:0] cnt, input logic [4:0] lim);
    fits = (cnt != 8'h00) && (({1'b0, addr} + {9'h000, cnt}) <= {12'h000, lim});
  endfunction

  // Configuration and table state.
  logic          map_en;
  logic [7:0]    local_unit;
  logic [4:0]    in_words;
  logic [4:0]    out_words;
  logic [31:0]   tbl_ip   [TBL_N];
  logic [7:0]    tbl_unit [TBL_N];
  logic [15:0]   tbl_tmo  [TBL_N];

  // Request engine state.
  mbm_state_t    state;
  logic          cur_map;
  logic          cur_rbank;
  logic [15:0]   raddr;
  logic [7:0]    rcnt;
  logic [15:0]   waddr;
  logic [7:0]    wcnt;
  logic          last_app;
  logic          app_rd_q;

  // Connection retry state.
  logic [3:0]    conn_idx;
  logic [15:0]   tmo_left;
  logic [31:0]   tick_cnt;
  logic [15:0]   ram_rdata;

  // APB decode.
  wire           apb_setup = psel && !penable;
  wire           apb_wr    = psel && penable && pwrite;
  wire           hit_ctrl  = (paddr == CTRL_OFS);
  wire           hit_size  = (paddr == SIZE_OFS);
  wire           hit_stat  = (paddr == STAT_OFS);
  wire           hit_tbl   = (paddr[11:8] == TBL_PAGE) && (paddr[1:0] == 2'b00);
  wire [3:0]     tidx      = paddr[7:4];
  wire [1:0]     tfld      = paddr[3:2];
  wire           mapped_ok = hit_ctrl || hit_size || hit_stat || hit_tbl;
  wire [7:0]     new_unit  = pwdata[CTRL_UNIT_LSB +: 8];
  wire [4:0]     new_in    = pwdata[SIZE_IN_LSB +: 5];
  wire [4:0]     new_out   = pwdata[SIZE_OUT_LSB +: 5];
  wire           unit_ok   = (new_unit >= LUNIT_MIN) && (new_unit <= LUNIT_MAX);
  wire           in_ok     = (new_in >= WORDS_MIN) && (new_in <= WORDS_MAX);
  wire           out_ok    = (new_out >= WORDS_MIN) && (new_out <= WORDS_MAX);
  wire [4:0]     idx_one   = {1'b0, tidx} + 5'h01;
  wire           tidx_act  = conn_idx == tidx;
  wire [31:0]    tbl_word  = (tfld == F_IP)   ? tbl_ip[tidx] :
                             (tfld == F_UNIT) ? {24'h0, tbl_unit[tidx]} :
                             (tfld == F_TMO)  ? {16'h0, tbl_tmo[tidx]} :
                             {14'h0, tidx_act && conn_fail, tidx_act && conn_try, 11'h0, idx_one};
  wire [31:0]    stat_word = {12'h0, conn_idx, rsp_exc, 5'h0, state != st_idle, conn_fail, conn_try};
  wire [31:0]    rd_word   = hit_ctrl ? {16'h0, local_unit, 7'h0, map_en} :
                             hit_size ? {19'h0, out_words, 3'h0, in_words} :
                             hit_stat ? stat_word :
                             hit_tbl  ? tbl_word : 32'h0;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped_ok;

  // Prdata is sampled in the setup cycle so the access phase needs no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (apb_setup && !pwrite) begin
      prdata <= rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_en     <= 1'b0;
      local_unit <= LUNIT_RST;
      in_words   <= WORDS_RST;
      out_words  <= WORDS_RST;
    end else if (apb_wr && hit_ctrl) begin
      map_en <= pwdata[CTRL_EN_BIT];
      if (unit_ok) begin
        local_unit <= new_unit;
      end
    end else if (apb_wr && hit_size) begin
      if (in_ok) begin
        in_words <= new_in;
      end
      if (out_ok) begin
        out_words <= new_out;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < TBL_N; i++) begin
        tbl_ip[i]   <= IP_RST;
        tbl_unit[i] <= RUNIT_RST;
        tbl_tmo[i]  <= TMO_RST;
      end
    end else if (apb_wr && hit_tbl) begin
      if (tfld == F_IP) begin
        tbl_ip[tidx] <= pwdata;
      end else if (tfld == F_UNIT) begin
        tbl_unit[tidx] <= pwdata[7:0];
      end else if (tfld == F_TMO) begin
        tbl_tmo[tidx] <= pwdata[15:0];
      end
    end
  end

  // Request classification at acceptance.
  wire           accept   = req_valid && (state == st_idle);
  wire           map_now  = map_en && (req_unit == local_unit) && (req_unit != UNIT_BCAST);
  wire           has_w    = (req_func == FC_WR1) || (req_func == FC_WRN) || (req_func == FC_RW);
  wire           has_r    = (req_func == FC_RD_OUT) || (req_func == FC_RD_IN) || (req_func == FC_RW);
  wire [7:0]     wcnt_in  = (req_func == FC_WR1) ? 8'h01 : req_wcount;
  wire           rd_in    = (req_func == FC_RD_IN);
  wire [4:0]     rd_lim   = rd_in ? in_words : out_words;
  wire           bad_r    = has_r && !fits(req_raddr, req_rcount, rd_lim);
  wire           bad_w    = has_w && !fits(req_waddr, wcnt_in, in_words);
  wire [7:0]     exc_now  = !(has_w || has_r) ? EXC_FUNC : (map_now && (bad_r || bad_w)) ? EXC_ADDR : EXC_NONE;

  // Fair sharing of the bank memory between the two paths.
  wire           eng_want = cur_map && (((state == st_write) && req_wvalid) || (state == st_read));
  wire           eng_gnt  = eng_want && (!app_valid || last_app);
  wire           app_gnt  = app_valid && !eng_gnt;
  wire           path_go  = cur_map ? eng_gnt : gm_ready;
  wire           ram_en   = eng_gnt || app_gnt;
  wire           ram_we   = eng_gnt ? (state == st_write) : app_we;
  wire [5:0]     eng_ra   = (state == st_write) ? {BANK_IN, waddr[BANK_AW-1:0]} : {cur_rbank, raddr[BANK_AW-1:0]};
  wire [5:0]     ram_addr = eng_gnt ? eng_ra : {app_bank, app_addr};
  wire [15:0]    ram_wd   = eng_gnt ? req_wdata : app_wdata;

  assign req_ready  = (state == st_idle);
  assign req_wready = (state == st_write) && path_go;
  assign app_ready  = app_gnt;
  assign gm_valid   = !cur_map && (((state == st_write) && req_wvalid) || (state == st_read));
  assign gm_we      = (state == st_write);
  assign gm_addr    = (state == st_write) ? waddr : raddr;
  assign gm_wdata   = req_wdata;
  assign app_rdata  = ram_rdata;

  mbm_word_ram #(
    .DW (16),
    .AW (BANK_AW + 1)
  ) u_banks (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (ram_en),
    .we      (ram_we),
    .addr    (ram_addr),
    .wdata   (ram_wd),
    .rdata   (ram_rdata)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_app   <= 1'b0;
      app_rd_q   <= 1'b0;
    end else begin
      app_rd_q <= app_gnt && !app_we;
      if (eng_want && app_valid) begin
        last_app <= app_gnt;
      end
    end
  end
  assign app_rvalid = app_rd_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= st_idle;
      cur_map    <= 1'b0;
      cur_rbank  <= BANK_OUT;
      raddr      <= 16'h0;
      rcnt       <= 8'h0;
      waddr      <= 16'h0;
      wcnt       <= 8'h0;
      rsp_rvalid <= 1'b0;
      rsp_rdata  <= 16'h0;
      rsp_done   <= 1'b0;
      rsp_exc    <= EXC_NONE;
    end else begin
      rsp_rvalid <= 1'b0;
      rsp_done   <= 1'b0;
      case (state)
        st_idle: if (accept) begin
          cur_map   <= map_now;
          cur_rbank <= rd_in ? BANK_IN : BANK_OUT;
          raddr     <= req_raddr;
          rcnt      <= has_r ? req_rcount : 8'h00;
          waddr     <= req_waddr;
          wcnt      <= has_w ? wcnt_in : 8'h00;
          rsp_exc   <= exc_now;
          if (exc_now != EXC_NONE || (has_w ? wcnt_in : req_rcount) == 8'h00) begin
            state <= st_done;
          end else begin
            state <= has_w ? st_write : st_read;
          end
        end
        st_write: if (req_wvalid && path_go) begin
          waddr <= waddr + 16'h0001;
          wcnt  <= wcnt - 8'h01;
          if (wcnt == 8'h01) begin
            state <= (rcnt != 8'h00) ? st_read : st_done;
          end
        end
        st_read: if (path_go) begin
          state <= st_rwait;
        end
        st_rwait: begin
          rsp_rvalid <= 1'b1;
          rsp_rdata  <= cur_map ? ram_rdata : gm_rdata;
          raddr      <= raddr + 16'h0001;
          rcnt       <= rcnt - 8'h01;
          state      <= (rcnt == 8'h01) ? st_done : st_read;
        end
        st_done: begin
          rsp_done <= 1'b1;
          state    <= st_idle;
        end
        default: state <= st_idle;
      endcase
    end
  end

  // The tick runs free, so the first tick of an attempt may come early by up to one period.
  wire           tick = (tick_cnt == TICK_CYCLES - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conn_idx  <= 4'h0;
      conn_try  <= 1'b0;
      conn_fail <= 1'b0;
      conn_ip   <= IP_RST;
      conn_unit <= RUNIT_RST;
      tmo_left  <= 16'h0;
    end else if (xchg_req) begin
      conn_idx  <= xchg_idx;
      conn_try  <= 1'b1;
      conn_fail <= 1'b0;
      conn_ip   <= tbl_ip[xchg_idx];
      conn_unit <= tbl_unit[xchg_idx];
      tmo_left  <= tbl_tmo[xchg_idx];
    end else if (conn_try && conn_up) begin
      conn_try <= 1'b0;
    end else if (conn_try && tmo_left == 16'h0) begin
      conn_try  <= 1'b0;
      conn_fail <= 1'b1;
    end else if (conn_try && tick) begin
      tmo_left <= tmo_left - 16'h0001;
    end
  end
endmodule

// File: core/mbm_pkg.sv
package mbm_pkg;

  // APB register map, byte addresses.
  localparam logic [11:0] CTRL_OFS  = 12'h000;
  localparam logic [11:0] SIZE_OFS  = 12'h004;
  localparam logic [11:0] STAT_OFS  = 12'h008;
  localparam logic [3:0]  TBL_PAGE  = 4'h1;
  localparam logic [1:0]  F_IP      = 2'h0;
  localparam logic [1:0]  F_UNIT    = 2'h1;
  localparam logic [1:0]  F_TMO     = 2'h2;
  localparam logic [1:0]  F_INFO    = 2'h3;

  // Field positions.
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_UNIT_LSB = 8;
  localparam int SIZE_IN_LSB   = 0;
  localparam int SIZE_OUT_LSB  = 8;
  localparam int STAT_EXC_LSB  = 8;
  localparam int STAT_IDX_LSB  = 16;

  // Reset values and legal ranges.
  localparam logic [31:0] IP_RST     = 32'h0000_0000;
  localparam logic [7:0]  RUNIT_RST  = 8'hff;
  localparam logic [15:0] TMO_RST    = 16'h0064;
  localparam logic [7:0]  LUNIT_RST  = 8'h01;
  localparam logic [7:0]  LUNIT_MIN  = 8'h01;
  localparam logic [7:0]  LUNIT_MAX  = 8'hf7;
  localparam logic [7:0]  UNIT_BCAST = 8'hff;
  localparam logic [4:0]  WORDS_RST  = 5'h0a;
  localparam logic [4:0]  WORDS_MIN  = 5'h01;
  localparam logic [4:0]  WORDS_MAX  = 5'h14;
  localparam int          TBL_N      = 16;

  // Bank layout in the shared word memory.
  localparam int         BANK_AW = 5;
  localparam logic       BANK_IN  = 1'b0;
  localparam logic       BANK_OUT = 1'b1;

  // Function and exception codes.
  localparam logic [7:0] FC_RD_OUT = 8'h03;
  localparam logic [7:0] FC_RD_IN  = 8'h04;
  localparam logic [7:0] FC_WR1    = 8'h06;
  localparam logic [7:0] FC_WRN    = 8'h10;
  localparam logic [7:0] FC_RW     = 8'h17;
  localparam logic [7:0] EXC_NONE  = 8'h00;
  localparam logic [7:0] EXC_FUNC  = 8'h01;
  localparam logic [7:0] EXC_ADDR  = 8'h02;

  // Retry tick.
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_MS       = 100;
  localparam int TICK_CYCLES   = TICK_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    st_idle  = 3'b000,
    st_write = 3'b001,
    st_read  = 3'b011,
    st_rwait = 3'b010,
    st_done  = 3'b110
  } mbm_state_t;

endpackage

// File: core/mbm_word_ram.sv
`timescale 1ns/100ps
module mbm_word_ram #(
  parameter int DW = 16,
  parameter int AW = 6
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  // The array has no reset so that it maps onto block memory.
  always_ff @(posedge pclk) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else if (en && !we) begin
      rdata <= mem[addr];
    end
  end
endmodule

// File: verification/mbm_server_monitor.sv
`timescale 1ns/100ps
module mbm_server_monitor
  import mbm_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pslverr,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [7:0]  req_unit,
  input wire logic [7:0]  req_func,
  input wire logic        rsp_done,
  input wire logic [7:0]  rsp_exc,
  input wire logic        xchg_req,
  input wire logic        conn_up,
  input wire logic        conn_try,
  input wire logic        conn_fail
);
  wire logic bad_fc;
  assign bad_fc = !(req_func inside {FC_RD_OUT, FC_RD_IN, FC_WR1, FC_WRN, FC_RW});
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_func_end;
    (rsp_exc == EXC_FUNC && !rsp_done) ##1 rsp_done;
  endsequence
  a_func_refuse: assert property (s_take ##0 bad_fc |-> ##1 s_func_end)
    else $error("unknown function not refused in two cycles");
  a_bcast_plain: assert property (s_take ##0 req_unit == UNIT_BCAST |=> rsp_exc != EXC_ADDR)
    else $error("broadcast unit raised address exception");
  a_done_bound: assert property (s_take |-> ##[2:200] rsp_done)
    else $error("request never finished");
  a_take_busy: assert property (s_take |=> !req_ready && !rsp_done)
    else $error("engine idle right after acceptance");
  a_table_noerr: assert property (psel && penable && paddr[11:8] == TBL_PAGE |-> !pslverr)
    else $error("table entry address refused");
  a_ctrl_noerr: assert property (psel && penable && paddr == CTRL_OFS |-> !pslverr)
    else $error("control register refused");
  a_conn_start: assert property (xchg_req |=> conn_try && !conn_fail)
    else $error("exchange did not start an attempt");
  a_fail_hold: assert property (conn_fail && !xchg_req |=> conn_fail)
    else $error("failure flag dropped without exchange");
  a_try_end: assert property (conn_try && conn_up && !xchg_req |=> !conn_try && !conn_fail)
    else $error("attempt kept on after connection");
endmodule

// File: verification/mbm_gm_model.sv
`timescale 1ns/100ps
module mbm_gm_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        gm_slow,
  input  wire logic        gm_valid,
  input  wire logic        gm_we,
  input  wire logic [15:0] gm_addr,
  input  wire logic [15:0] gm_wdata,
  output logic             gm_ready,
  output logic      [15:0] gm_rdata
);
  logic [15:0] mem [256];
  logic        tog;
  // Stalling on alternate cycles forces the server to hold its request.
  assign gm_ready = !gm_slow || tog;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog <= 1'b0;
      gm_rdata <= 16'h0000;
      for (int i = 0; i < 256; i++) mem[i] <= 16'h5000 + 16'(i);
    end else begin
      tog <= !tog;
      // Read data is good only in the cycle after the read is taken.
      if (gm_valid && gm_ready && !gm_we) mem[0] <= mem[0];
      if (gm_valid && gm_ready && !gm_we) gm_rdata <= mem[gm_addr[7:0]];
      else gm_rdata <= ~gm_rdata;
      if (gm_valid && gm_ready && gm_we) mem[gm_addr[7:0]] <= gm_wdata;
    end
  end
endmodule

// File: verification/mbm_server_tb_top.sv
`timescale 1ns/100ps
module mbm_server_tb_top;
  import mbm_pkg::*;
  typedef struct {logic [7:0] unit, func; logic [15:0] a; logic [7:0] c; logic [15:0] wd; logic [7:0] exc;
                  logic [15:0] rd;} mbm_row_t;
  typedef struct {logic [11:0] a; logic [31:0] v; logic e;} mbm_apb_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, gm_slow, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q32, conn_ip;
  logic        req_valid, req_ready, req_wvalid, req_wready, rsp_rvalid, rsp_done;
  logic [7:0]  req_unit, req_func, req_rcount, req_wcount, rsp_exc, conn_unit;
  logic [15:0] req_raddr, req_waddr, req_wdata, rsp_rdata, gm_addr, gm_wdata, gm_rdata, app_wdata, app_rdata, q16;
  logic        gm_valid, gm_we, gm_ready, app_valid, app_we, app_bank, app_ready, app_rvalid;
  logic [4:0]  app_addr;
  logic        xchg_req, conn_up, conn_try, conn_fail;
  logic [3:0]  xchg_idx;
  int          err_count = 0, checks_done = 0, cyc = 0;
  mbm_apb_t regs [9] = '{'{CTRL_OFS, 32'h0000_0100, 1'b0}, '{SIZE_OFS, 32'h0000_0a0a, 1'b0},
    '{STAT_OFS, 32'h0, 1'b0}, '{12'h100, 32'h0, 1'b0}, '{12'h104, 32'h0000_00ff, 1'b0},
    '{12'h108, 32'h0000_0064, 1'b0}, '{12'h10c, 32'h0000_0001, 1'b0}, '{12'h1fc, 32'h0000_0010, 1'b0},
    '{12'h00c, 32'h0, 1'b1}};
  mbm_row_t rows [15] = '{
    '{8'h05, 8'h10, 16'h0000, 8'h0a, 16'hb000, 8'h00, 16'h0000},
    '{8'h05, 8'h04, 16'h0000, 8'h0a, 16'h0000, 8'h00, 16'hb000},
    '{8'h05, 8'h06, 16'h0003, 8'h01, 16'hc000, 8'h00, 16'h0000},
    '{8'h05, 8'h04, 16'h0003, 8'h01, 16'h0000, 8'h00, 16'hc000},
    '{8'h05, 8'h03, 16'h0009, 8'h01, 16'h0000, 8'h00, 16'ha009},
    '{8'h05, 8'h03, 16'h0009, 8'h02, 16'h0000, 8'h02, 16'h0000},
    '{8'h05, 8'h17, 16'h0000, 8'h02, 16'hd000, 8'h00, 16'ha000},
    '{8'h05, 8'h04, 16'h0000, 8'h01, 16'h0000, 8'h00, 16'hd000},
    '{8'h05, 8'h05, 16'h0000, 8'h01, 16'h0000, 8'h01, 16'h0000},
    '{8'h05, 8'h04, 16'h0000, 8'h00, 16'h0000, 8'h02, 16'h0000},
    '{8'h05, 8'h06, 16'h000a, 8'h01, 16'h0000, 8'h02, 16'h0000},
    '{8'h07, 8'h10, 16'h0028, 8'h02, 16'he000, 8'h00, 16'h0000},
    '{8'h07, 8'h03, 16'h0028, 8'h02, 16'h0000, 8'h00, 16'he000},
    '{8'h07, 8'h03, 16'h001e, 8'h05, 16'h0000, 8'h00, 16'h501e},
    '{8'hff, 8'h04, 16'h0001, 8'h01, 16'h0000, 8'h00, 16'h5001}};

  mbm_server #(.TICK_CYCLES(20)) dut (.*);
  mbm_gm_model gm_model (.*);

  task automatic wrap_up;
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic app(input logic w, input logic b, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
    app_valid <= 1'b1;
    app_we <= w;
    app_bank <= b;
    app_addr <= a;
    app_wdata <= d;
    do @(posedge pclk); while (app_ready !== 1'b1);
    app_valid <= 1'b0;
    @(posedge pclk);
    q = app_rdata;
    if (!w) chk(32'(app_rvalid), 32'h1, "bank read strobe");
  endtask

  task automatic reqchk(input mbm_row_t r);
    logic [15:0] q [$];
    int          k, n, wn;
    logic        tw;
    k = 0;
    wn = (r.func inside {FC_WR1, FC_WRN, FC_RW}) ? int'(r.c) : 0;
    n = (r.exc == EXC_NONE && r.func inside {FC_RD_OUT, FC_RD_IN, FC_RW}) ? int'(r.c) : 0;
    req_valid <= 1'b1;
    {req_unit, req_func, req_raddr, req_waddr, req_rcount, req_wcount} <= {r.unit, r.func, r.a, r.a, r.c, r.c};
    req_wdata <= r.wd;
    req_wvalid <= (wn > 0);
    do @(posedge pclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    forever begin
      @(negedge pclk);
      if (rsp_rvalid === 1'b1) q.push_back(rsp_rdata);
      if (rsp_done === 1'b1) break;
      tw = req_wvalid && req_wready;
      @(posedge pclk);
      if (tw) begin
        k++;
        req_wdata <= r.wd + 16'(k);
        if (k == wn) req_wvalid <= 1'b0;
      end
    end
    @(posedge pclk);
    chk(32'(rsp_exc), 32'(r.exc), "exception code");
    chk(32'(q.size()), 32'(n), "word count");
    for (int i = 0; i < q.size(); i++) chk(32'(q[i]), 32'(r.rd + 16'(i)), "word data");
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      $display("ERROR %0t run did not finish", $time);
      wrap_up;
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, req_valid, req_wvalid, gm_slow, app_valid, app_we, app_bank} = '0;
    {xchg_req, conn_up, xchg_idx, paddr, pwdata, req_unit, req_func, req_rcount, req_wcount} = '0;
    {req_raddr, req_waddr, req_wdata, app_wdata, app_addr} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[i]) begin
      apb(1'b0, regs[i].a, 32'h0, q32, e);
      chk(q32, regs[i].v, "reset value");
      chk(32'(e), 32'(regs[i].e), "slave error");
    end
    for (int i = 0; i < 20; i++) app(1'b1, 1'b1, 5'(i), 16'ha000 + 16'(i), q16);
    reqchk('{8'h01, 8'h03, 16'h0000, 8'h01, 16'h0000, 8'h00, 16'h5000});
    apb(1'b1, CTRL_OFS, 32'h0000_f801, q32, e);
    apb(1'b0, CTRL_OFS, 32'h0, q32, e);
    chk(q32, 32'h0000_0101, "unit range");
    apb(1'b1, CTRL_OFS, 32'h0000_0501, q32, e);
    foreach (rows[i]) begin
      gm_slow <= (i > 10);
      reqchk(rows[i]);
    end
    apb(1'b1, SIZE_OFS, 32'h0000_1404, q32, e);
    reqchk('{8'h05, 8'h03, 16'h0013, 8'h01, 16'h0000, 8'h00, 16'ha013});
    reqchk('{8'h05, 8'h10, 16'h0003, 8'h02, 16'hf000, 8'h02, 16'h0000});
    fork
      app(1'b0, 1'b1, 5'h00, 16'h0000, q16);
      reqchk('{8'h05, 8'h03, 16'h0001, 8'h01, 16'h0000, 8'h00, 16'ha001});
    join
    chk(32'(q16), 32'h0000_a000, "bank read");
    apb(1'b1, 12'h110, 32'h0a00_0002, q32, e);
    apb(1'b1, 12'h114, 32'h0000_0011, q32, e);
    apb(1'b1, 12'h118, 32'h0000_0002, q32, e);
    xchg_idx <= 4'h1;
    xchg_req <= 1'b1;
    @(posedge pclk);
    xchg_req <= 1'b0;
    @(negedge pclk);
    chk(conn_ip, 32'h0a00_0002, "target address");
    chk(32'(conn_unit), 32'h0000_0011, "target unit");
    repeat (15) @(negedge pclk);
    chk(32'(conn_try), 32'h1, "still trying");
    repeat (30) @(negedge pclk);
    chk({30'h0, conn_fail, conn_try}, 32'h2, "given up");
    @(posedge pclk);
    apb(1'b0, STAT_OFS, 32'h0, q32, e);
    chk(q32, 32'h0001_0002, "status word");
    xchg_req <= 1'b1;
    @(posedge pclk);
    xchg_req <= 1'b0;
    conn_up <= 1'b1;
    repeat (3) @(negedge pclk);
    chk({30'h0, conn_fail, conn_try}, 32'h0, "connected");
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, CTRL_OFS, 32'h0, q32, e);
    chk(q32, 32'h0000_0100, "control after reset");
    reqchk('{8'h05, 8'h03, 16'h0000, 8'h01, 16'h0000, 8'h00, 16'h5000});
    wrap_up;
  end
endmodule

bind mbm_server mbm_server_monitor mon (.*);
